// ==== autoreload_timer_params.svh ====
// Register offsets, field positions and reset values of the auto-reload PWM timer
`ifndef AUTORELOAD_TIMER_PARAMS_SVH
`define AUTORELOAD_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_CSR 8'h0d
`define OFF_CNT_H 8'h0e
`define OFF_CNT_L 8'h0f
`define OFF_RLD_H 8'h10
`define OFF_RLD_L 8'h11
`define OFF_OE 8'h12
`define OFF_CH_CSR0 8'h13
`define OFF_DUTY0_H 8'h17
`define OFF_CAP_H 8'h1f
`define OFF_CAP_L 8'h20
`define OFF_XFER 8'h21
`define OFF_BRK 8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSR_CAPF 6
`define CSR_CAPIE 5
`define CSR_SEL_HI 4
`define CSR_SEL_LO 3
`define CSR_WRAPF 2
`define CSR_WRAPIE 1
`define CSR_MATCHIE 0
`define CHC_INV 1
`define CHC_MATCHF 0
`define BRK_ACTIVE 5
`define BRK_PINEN 4
`define XFER_EN 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CNT_RESET 12'h000
`define CNT_MAX 12'hfff
`define XFER_RESET 1'b1
`define SLOW_DIV_LAST 5'h1f

`endif

// ==== autoreload_timer_pkg.sv ====
// Types shared by the auto-reload PWM timer
package autoreload_timer_pkg;

  // Encoding follows the two-bit source select field, 00 to 11
  typedef enum logic [1:0] {SRC_OFF, SRC_SLOW, SRC_CPU, SRC_FAST} count_src_t;

endpackage : autoreload_timer_pkg

// ==== autoreload_pwm_timer.sv ====
// Auto-reload 12-bit timer with four PWM channels, break and capture
`timescale 1ns/100ps
`include "autoreload_timer_params.svh"

module autoreload_pwm_timer
  import autoreload_timer_pkg::*;
#(
  parameter int CH = 4,
  parameter int CW = 12
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic slowTick,
  input wire logic fastTick,
  input wire logic slowMode,
  input wire logic haltMode,
  input wire logic activeHaltMode,
  input wire logic cpuIrqMask,
  input wire logic breakPin_n,
  input wire logic captureInputPin,
  input wire logic [CH-1:0] portData,
  output logic [CH-1:0] pwmPin,
  output logic [CH-1:0] pwmPinEn,
  output logic irqWrap,
  output logic irqMatchCap,
  output logic wakeUp
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [7:0] hiByte(input logic [CW-1:0] v);
    hiByte = {4'h0, v[CW-1:8]};
  endfunction : hiByte

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CW-1:0] count_reg;
  logic [CW-1:0] reloadValue_reg;
  logic [3:0] cntHiLatch_reg;
  logic countMoved_reg;
  logic [4:0] slowDiv_reg;
  count_src_t activeSrc_reg;
  logic [1:0] sourceSelect_reg;
  logic captureIrqEnable_reg;
  logic wrapIrqEnable_reg;
  logic matchIrqEnable_reg;
  logic wrapFlag_reg;
  logic captureFlag_reg;
  logic [CW-1:0] captureValue_reg;
  logic [CH-1:0] outputEnable_reg;
  logic [CH-1:0] invertPre_reg;
  logic [CH-1:0] invertAct_reg;
  logic [CH-1:0] matchFlag_reg;
  logic [CH-1:0] pwmLevel_reg;
  logic [CH-1:0][CW-1:0] dutyPre_reg;
  logic [CH-1:0][CW-1:0] dutyAct_reg;
  logic shadowUpdate_reg;
  logic breakActive_reg;
  logic breakInputEnable_reg;
  logic [CH-1:0] breakPattern_reg;
  logic brkSyncA_reg;
  logic brkSyncB_reg;
  logic capSyncA_reg;
  logic capSyncB_reg;
  logic capPrev_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wrCsr = wr && hit(addr, `OFF_CSR);
  wire wrRldH = wr && hit(addr, `OFF_RLD_H);
  wire wrRldL = wr && hit(addr, `OFF_RLD_L);
  wire wrOe = wr && hit(addr, `OFF_OE);
  wire wrXfer = wr && hit(addr, `OFF_XFER);
  wire wrBrk = wr && hit(addr, `OFF_BRK);
  wire rdCsr = rd && hit(addr, `OFF_CSR);
  wire rdCntL = rd && hit(addr, `OFF_CNT_L);
  wire rdCap = rd && (hit(addr, `OFF_CAP_H) || hit(addr, `OFF_CAP_L));

  // ----------------------------------------------------------------
  // Counter clock source and halt modes
  // ----------------------------------------------------------------
  // Slow mode divides the CPU clock by 32
  wire cpuTick = !slowMode || (slowDiv_reg == `SLOW_DIV_LAST);
  wire keepInHalt = (activeSrc_reg == SRC_SLOW) && wrapIrqEnable_reg;
  wire halted = haltMode || (activeHaltMode && !keepInHalt);
  wire srcTick = (activeSrc_reg == SRC_SLOW) ? slowTick :
                 (activeSrc_reg == SRC_CPU) ? cpuTick :
                 (activeSrc_reg == SRC_FAST) ? fastTick : 1'b0;
  wire tick = srcTick && !halted && !breakActive_reg;
  wire atMax = (count_reg == `CNT_MAX);
  wire wrapEvent = tick && atMax;
  wire [CW-1:0] count_next = atMax ? reloadValue_reg : count_reg + 1'b1;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      slowDiv_reg <= 5'h00;
    else if (slowMode)
      slowDiv_reg <= slowDiv_reg + 5'h01;
    else
      slowDiv_reg <= 5'h00;
  end

  // A new source waits for a wrap; from off it starts at once, else the counter never runs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      activeSrc_reg <= SRC_OFF;
    else if (wrapEvent || activeSrc_reg == SRC_OFF)
      activeSrc_reg <= count_src_t'(sourceSelect_reg);
  end

  // ----------------------------------------------------------------
  // Upcounter and reload value
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= `CNT_RESET;
    else if (breakActive_reg)
      count_reg <= `CNT_RESET;
    else if (tick)
      count_reg <= count_next;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      countMoved_reg <= 1'b0;
    else
      countMoved_reg <= tick;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reloadValue_reg <= `CNT_RESET;
    else if (breakActive_reg)
      reloadValue_reg <= `CNT_RESET;
    else if (wrRldH)
      reloadValue_reg[CW-1:8] <= wdata[3:0];
    else if (wrRldL)
      reloadValue_reg[7:0] <= wdata;
  end

  // Low byte read first freezes the high nibble, so a two-byte read is coherent
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cntHiLatch_reg <= 4'h0;
    else if (rdCntL)
      cntHiLatch_reg <= count_reg[CW-1:8];
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sourceSelect_reg <= 2'h0;
      captureIrqEnable_reg <= 1'b0;
      wrapIrqEnable_reg <= 1'b0;
      matchIrqEnable_reg <= 1'b0;
    end
    else if (wrCsr)
    begin
      sourceSelect_reg <= wdata[`CSR_SEL_HI:`CSR_SEL_LO];
      captureIrqEnable_reg <= wdata[`CSR_CAPIE];
      wrapIrqEnable_reg <= wdata[`CSR_WRAPIE];
      matchIrqEnable_reg <= wdata[`CSR_MATCHIE];
    end
  end

  // Set wins over the read-clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wrapFlag_reg <= 1'b0;
    else if (wrapEvent)
      wrapFlag_reg <= 1'b1;
    else if (rdCsr)
      wrapFlag_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Shadow transfer control
  // ----------------------------------------------------------------
  wire doTransfer = wrapEvent && shadowUpdate_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      shadowUpdate_reg <= `XFER_RESET;
    else if (wrXfer)
      shadowUpdate_reg <= wdata[`XFER_EN];
    else if (doTransfer)
      shadowUpdate_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      outputEnable_reg <= '0;
    else if (breakActive_reg)
      outputEnable_reg <= '0;
    else if (wrOe)
      outputEnable_reg <= {wdata[6], wdata[4], wdata[2], wdata[0]};
  end

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  // Level falls as the counter steps onto duty; duty at or below reload never falls
  for (genvar i = 0; i < CH; i++)
  begin : g_ch
    wire [7:0] offCsr = `OFF_CH_CSR0 + 8'(i);
    wire [7:0] offDutyH = `OFF_DUTY0_H + 8'(2 * i);
    wire wrChCsr = wr && hit(addr, offCsr);
    wire rdChCsr = rd && hit(addr, offCsr);
    wire wrDutyH = wr && hit(addr, offDutyH);
    wire wrDutyL = wr && hit(addr, offDutyH + 8'h01);
    wire equal = countMoved_reg && (count_reg == dutyAct_reg[i]);
    wire reachDuty = tick && (count_next == dutyAct_reg[i]);
    wire matchEvent = equal && (dutyAct_reg[i] != '0);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        dutyPre_reg[i] <= '0;
      else if (breakActive_reg)
        dutyPre_reg[i] <= '0;
      else if (wrDutyH)
        dutyPre_reg[i][CW-1:8] <= wdata[3:0];
      else if (wrDutyL)
        dutyPre_reg[i][7:0] <= wdata;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        dutyAct_reg[i] <= '0;
      else if (breakActive_reg)
        dutyAct_reg[i] <= '0;
      else if (doTransfer)
        dutyAct_reg[i] <= dutyPre_reg[i];
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        invertPre_reg[i] <= 1'b0;
      else if (wrChCsr)
        invertPre_reg[i] <= wdata[`CHC_INV];
    end

    // With transfer enabled polarity moves only at a wrap, otherwise at once
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        invertAct_reg[i] <= 1'b0;
      else if (!shadowUpdate_reg || doTransfer)
        invertAct_reg[i] <= invertPre_reg[i];
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        pwmLevel_reg[i] <= 1'b0;
      else if (wrapEvent)
        pwmLevel_reg[i] <= 1'b1;
      else if (reachDuty)
        pwmLevel_reg[i] <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        matchFlag_reg[i] <= 1'b0;
      else if (matchEvent)
        matchFlag_reg[i] <= 1'b1;
      else if (rdChCsr)
        matchFlag_reg[i] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Break
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      brkSyncA_reg <= 1'b1;
      brkSyncB_reg <= 1'b1;
    end
    else
    begin
      brkSyncA_reg <= breakPin_n;
      brkSyncB_reg <= brkSyncA_reg;
    end
  end

  wire breakFromPin = breakInputEnable_reg && !brkSyncB_reg;

  // A held low pin keeps re-arming the break even against a software clear
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      breakActive_reg <= 1'b0;
    else if (breakFromPin)
      breakActive_reg <= 1'b1;
    else if (wrBrk)
      breakActive_reg <= wdata[`BRK_ACTIVE];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      breakInputEnable_reg <= 1'b0;
      breakPattern_reg <= '0;
    end
    else if (wrBrk)
    begin
      breakInputEnable_reg <= wdata[`BRK_PINEN];
      breakPattern_reg <= wdata[CH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      capSyncA_reg <= 1'b0;
      capSyncB_reg <= 1'b0;
      capPrev_reg <= 1'b0;
    end
    else
    begin
      capSyncA_reg <= captureInputPin;
      capSyncB_reg <= capSyncA_reg;
      capPrev_reg <= capSyncB_reg;
    end
  end

  wire capEdge = capSyncB_reg != capPrev_reg;
  wire capTake = capEdge && !captureFlag_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      captureValue_reg <= '0;
    else if (capTake)
      captureValue_reg <= count_reg;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      captureFlag_reg <= 1'b0;
    else if (capTake)
      captureFlag_reg <= 1'b1;
    else if (rdCap)
      captureFlag_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pins and requests
  // ----------------------------------------------------------------
  // The slow source is too coarse for PWM, so its pins fall back to port data
  wire pwmAllowed = activeSrc_reg != SRC_SLOW;
  wire [CH-1:0] chOn = outputEnable_reg & {CH{pwmAllowed}};
  wire [CH-1:0] chWave = pwmLevel_reg ^ invertAct_reg;
  wire [CH-1:0] pinNext = breakActive_reg ? breakPattern_reg :
                          (chWave & chOn) | (portData & ~chOn);
  wire anyMatch = |matchFlag_reg;
  wire reqMatchCap = (anyMatch && matchIrqEnable_reg) ||
                     (captureFlag_reg && captureIrqEnable_reg);
  wire reqWrap = wrapFlag_reg && wrapIrqEnable_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwmPin <= '0;
      pwmPinEn <= '0;
    end
    else
    begin
      pwmPin <= pinNext;
      pwmPinEn <= chOn | {CH{breakActive_reg}};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqWrap <= 1'b0;
      irqMatchCap <= 1'b0;
      wakeUp <= 1'b0;
    end
    else
    begin
      irqWrap <= reqWrap && !cpuIrqMask;
      irqMatchCap <= reqMatchCap && !cpuIrqMask;
      wakeUp <= reqWrap && activeHaltMode && keepInHalt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] csrRead = {1'b0, captureFlag_reg, captureIrqEnable_reg, sourceSelect_reg,
                        wrapFlag_reg, wrapIrqEnable_reg, matchIrqEnable_reg};
  wire [7:0] oeRead = {1'b0, outputEnable_reg[3], 1'b0, outputEnable_reg[2],
                       1'b0, outputEnable_reg[1], 1'b0, outputEnable_reg[0]};
  wire [7:0] brkRead = {2'b00, breakActive_reg, breakInputEnable_reg, breakPattern_reg};
  wire [7:0] chIdx = addr - `OFF_CH_CSR0;
  wire [7:0] dutyIdx = addr - `OFF_DUTY0_H;
  wire inCh = (addr >= `OFF_CH_CSR0) && (chIdx < 8'(CH));
  wire inDuty = (addr >= `OFF_DUTY0_H) && (dutyIdx < 8'(2 * CH));
  wire [1:0] chSel = chIdx[1:0];
  wire [1:0] dutySel = dutyIdx[2:1];
  wire [CW-1:0] dutyPick = dutyPre_reg[dutySel];
  wire [7:0] chRead = {6'h00, invertPre_reg[chSel], matchFlag_reg[chSel]};
  wire [7:0] dutyRead = dutyIdx[0] ? dutyPick[7:0] : hiByte(dutyPick);
  wire [7:0] readNext =
    hit(addr, `OFF_CSR) ? csrRead :
    hit(addr, `OFF_CNT_H) ? {4'h0, cntHiLatch_reg} :
    hit(addr, `OFF_CNT_L) ? count_reg[7:0] :
    hit(addr, `OFF_RLD_H) ? hiByte(reloadValue_reg) :
    hit(addr, `OFF_RLD_L) ? reloadValue_reg[7:0] :
    hit(addr, `OFF_OE) ? oeRead :
    inCh ? chRead :
    inDuty ? dutyRead :
    hit(addr, `OFF_CAP_H) ? hiByte(captureValue_reg) :
    hit(addr, `OFF_CAP_L) ? captureValue_reg[7:0] :
    hit(addr, `OFF_XFER) ? {7'h00, shadowUpdate_reg} :
    hit(addr, `OFF_BRK) ? brkRead : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= readNext;
    else
      rdata <= 8'h00;
  end

endmodule : autoreload_pwm_timer

// ==== autoreload_pwm_timer_chk.sv ====
// Port-level checker for the auto-reload PWM timer
`timescale 1ns/100ps
`include "autoreload_timer_params.svh"

module autoreload_pwm_timer_chk
#(
  parameter int CH = 4
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic slowTick,
  input wire logic fastTick,
  input wire logic slowMode,
  input wire logic haltMode,
  input wire logic activeHaltMode,
  input wire logic cpuIrqMask,
  input wire logic breakPin_n,
  input wire logic captureInputPin,
  input wire logic [CH-1:0] portData,
  input wire logic [CH-1:0] pwmPin,
  input wire logic [CH-1:0] pwmPinEn,
  input wire logic irqWrap,
  input wire logic irqMatchCap,
  input wire logic wakeUp
);
  // ------
  // Shadow copies of software-written control bits
  // ------
  logic [7:0] brkReg;
  logic [7:0] csrReg;
  logic [7:0] rsvdMask;
  wire brkWr = wr && addr == `OFF_BRK;
  wire csrWr = wr && addr == `OFF_CSR;
  wire dutyHi = addr >= `OFF_DUTY0_H && addr < `OFF_CAP_H && addr[0];
  wire chCsr = addr >= `OFF_CH_CSR0 && addr < `OFF_DUTY0_H;
  wire hiByte = addr == `OFF_CNT_H || addr == `OFF_RLD_H || addr == `OFF_CAP_H || dutyHi;
  // Unmapped places read as all reserved
  assign rsvdMask = (addr < `OFF_CSR || addr > `OFF_BRK) ? 8'hff : hiByte ? 8'hf0 :
    (addr == `OFF_CSR) ? 8'h80 : (addr == `OFF_OE) ? 8'haa : chCsr ? 8'hfc :
    (addr == `OFF_XFER) ? 8'hfe : (addr == `OFF_BRK) ? 8'hc0 : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      brkReg <= 8'h00;
      csrReg <= 8'h00;
    end
    else
    begin
      if (brkWr)
        brkReg <= wdata;
      if (csrWr)
        csrReg <= wdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  reserved_bits_a: assert property (rd |=> (rdata & $past(rsvdMask)) == 8'h00)
    else $error("reserved or unmapped bits read nonzero");
  irq_mask_a: assert property (cpuIrqMask |=> !irqWrap && !irqMatchCap)
    else $error("request raised while masked");
  wrap_enable_a: assert property (!csrReg[`CSR_WRAPIE] |=> !irqWrap)
    else $error("wrap request without its enable");
  match_cap_en_a: assert property (!csrReg[`CSR_MATCHIE] && !csrReg[`CSR_CAPIE]
    |=> !irqMatchCap)
    else $error("match or capture request without enable");
  wake_cond_a: assert property (!(activeHaltMode && csrReg[`CSR_WRAPIE]) |=> !wakeUp)
    else $error("wake raised outside active halt with wrap enable");
  halt_hold_a: assert property ((haltMode && !wr && breakPin_n && $stable(portData))[*4]
    |-> $stable(pwmPin))
    else $error("pins moved while halted");
  break_pin_a: assert property ((brkReg[`BRK_PINEN] && !breakPin_n && !brkWr)[*3]
    |-> ##2 (pwmPin == brkReg[3:0] && pwmPinEn == '1))
    else $error("break pin did not force the pattern");
  sw_break_a: assert property (brkWr && wdata[`BRK_ACTIVE] |-> ##2 pwmPin == brkReg[3:0])
    else $error("software break did not force the pattern");

  wrap_irq_c: cover property (irqWrap);
  sw_break_c: cover property (brkWr && wdata[`BRK_ACTIVE]);
  halt_run_c: cover property (haltMode && pwmPinEn != '0);
endmodule : autoreload_pwm_timer_chk

bind autoreload_pwm_timer autoreload_pwm_timer_chk #(.CH(CH)) i_autoreload_pwm_timer_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .slowTick(slowTick), .fastTick(fastTick), .slowMode(slowMode),
  .haltMode(haltMode), .activeHaltMode(activeHaltMode), .cpuIrqMask(cpuIrqMask),
  .breakPin_n(breakPin_n), .captureInputPin(captureInputPin), .portData(portData),
  .pwmPin(pwmPin), .pwmPinEn(pwmPinEn), .irqWrap(irqWrap), .irqMatchCap(irqMatchCap),
  .wakeUp(wakeUp));

// ==== power_stage_model.sv ====
// Power stage model: fault comparator, sense line and channel 0 pulse timing
`timescale 1ns/100ps

module power_stage_model
#(
  parameter int FAULT_LAT = 1
)
(
  input wire logic clk_sys,
  input wire logic [3:0] pwmPin,
  input wire logic [3:0] pwmPinEn,
  input wire logic faultReq,
  input wire logic senseFlip,
  output logic breakPin_n,
  output logic captureInputPin,
  output logic [12:0] highLen,
  output logic [12:0] periodLen,
  output logic measDone
);
  logic [7:0] latCnt;
  logic [12:0] runCnt;
  logic [12:0] hiCnt;
  logic lastPin;

  // Break line has a pull-up, so it idles high with no fault
  initial
  begin
    breakPin_n = 1'b1;
    captureInputPin = 1'b0;
    latCnt = 8'h00;
    runCnt = 13'h0000;
    hiCnt = 13'h0000;
    lastPin = 1'b0;
    measDone = 1'b0;
  end

  always @(posedge clk_sys)
  begin
    lastPin <= pwmPin[0];
    latCnt <= faultReq ? latCnt + 8'h01 : 8'h00;
    breakPin_n <= !(faultReq && latCnt >= 8'(FAULT_LAT));
    captureInputPin <= captureInputPin ^ senseFlip;
    measDone <= 1'b0;
    // A rising edge closes one period and restarts both counts
    if (pwmPin[0] && !lastPin)
    begin
      periodLen <= runCnt;
      highLen <= hiCnt;
      measDone <= pwmPinEn[0];
      runCnt <= 13'h0001;
      hiCnt <= 13'h0001;
    end
    else
    begin
      runCnt <= runCnt + 13'h0001;
      hiCnt <= hiCnt + {12'h000, pwmPin[0]};
    end
  end
endmodule : power_stage_model

// ==== tb_top.sv ====
// Self-checking bench for the auto-reload PWM timer
`timescale 1ns/100ps
`include "autoreload_timer_params.svh"

module tb_top;
  logic clk_sys, reset_n, wr, rd, slowTick, fastTick, haltMode, activeHaltMode;
  logic cpuIrqMask, breakPin_n, captureInputPin, irqWrap, irqMatchCap, wakeUp;
  logic faultReq, senseFlip, measDone, slowMode;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] portData, pwmPin, pwmPinEn;
  logic [12:0] highLen, periodLen;
  logic [9:0] tickDiv = 10'h000;
  logic [15:0] rstTab [8] = '{16'h0d00, 16'h0e00, 16'h0f00, 16'h1100, 16'h1200, 16'h2101,
    16'h2200, 16'h3000};
  logic [7:0] srcTab [4] = '{8'h18, 8'h08, 8'h10, 8'h00};
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  autoreload_pwm_timer i_autoreload_pwm_timer (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slowTick(slowTick),
    .fastTick(fastTick), .slowMode(slowMode), .haltMode(haltMode),
    .activeHaltMode(activeHaltMode),
    .cpuIrqMask(cpuIrqMask), .breakPin_n(breakPin_n), .captureInputPin(captureInputPin),
    .portData(portData), .pwmPin(pwmPin), .pwmPinEn(pwmPinEn), .irqWrap(irqWrap),
    .irqMatchCap(irqMatchCap), .wakeUp(wakeUp));

  power_stage_model i_power_stage_model (.clk_sys(clk_sys), .pwmPin(pwmPin),
    .pwmPinEn(pwmPinEn), .faultReq(faultReq), .senseFlip(senseFlip),
    .breakPin_n(breakPin_n), .captureInputPin(captureInputPin), .highLen(highLen),
    .periodLen(periodLen), .measDone(measDone));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ------
  // Count sources and hang guard
  // ------
  always @(posedge clk_sys)
  begin
    tickDiv <= tickDiv + 10'h001;
    fastTick <= tickDiv[2:0] == 3'h7;
    slowTick <= tickDiv == 10'h3ff;
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wrReg

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    check({5'h00, rdata}, {5'h00, e});
  endtask : rdChk

  // Waits for n channel 0 periods, bounded so a dead output cannot hang
  task automatic waitMeas(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 6000)
    begin
      @(posedge clk_sys);
      #1;
      if (measDone === 1'b1)
        n--;
      k++;
    end
    check({12'h000, k < 6000}, 13'h0001);
  endtask : waitMeas

  task automatic wait1(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait1

  task automatic endTest(input string name);
    $display("test %s finished: %0d checks, %0d mismatches", name, num_checks, fail_count);
  endtask : endTest

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    haltMode = 1'b0;
    activeHaltMode = 1'b0;
    slowMode = 1'b0;
    cpuIrqMask = 1'b0;
    portData = 4'h5;
    faultReq = 1'b0;
    senseFlip = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rstTab[i])
      rdChk(rstTab[i][15:8], rstTab[i][7:0]);
    endTest("reset");
    // Reload 0xff0 gives a 16-cycle period; duty stays above reload
    wrReg(`OFF_RLD_H, 8'h0f);
    wrReg(`OFF_RLD_L, 8'hf0);
    wrReg(`OFF_DUTY0_H, 8'h0f);
    wrReg(`OFF_DUTY0_H + 8'h01, 8'hf4);
    wrReg(`OFF_OE, 8'h01);
    wrReg(`OFF_CSR, 8'h12);
    waitMeas(2);
    check(periodLen, 13'h0010);
    check(highLen, 13'h0004);
    slowMode <= 1'b1;
    waitMeas(2);
    check(periodLen, 13'h0200);
    slowMode <= 1'b0;
    check({9'h000, pwmPinEn}, 13'h0001);
    check({12'h000, irqWrap}, 13'h0001);
    cpuIrqMask <= 1'b1;
    wait1(3);
    check({12'h000, irqWrap}, 13'h0000);
    cpuIrqMask <= 1'b0;
    haltMode <= 1'b1;
    activeHaltMode <= 1'b1;
    wait1(10);
    check({12'h000, wakeUp}, 13'h0000);
    haltMode <= 1'b0;
    activeHaltMode <= 1'b0;
    wrReg(`OFF_XFER, 8'h01);
    wrReg(`OFF_CH_CSR0, 8'h02);
    waitMeas(3);
    check(highLen, 13'h000c);
    rdChk(`OFF_XFER, 8'h00);
    endTest("pwm");
    // Off is adopted at the next wrap, leaving the counter parked on reload
    wrReg(`OFF_CSR, 8'h02);
    wait1(40);
    rdChk(`OFF_CSR, 8'h06);
    rdChk(`OFF_CSR, 8'h02);
    rdChk(`OFF_CH_CSR0, 8'h03);
    rdChk(`OFF_CH_CSR0, 8'h02);
    rdChk(`OFF_CH_CSR0 + 8'h01, 8'h00);
    rdChk(`OFF_CNT_L, 8'hf0);
    rdChk(`OFF_CNT_H, 8'h0f);
    senseFlip <= 1'b1;
    wait1(1);
    senseFlip <= 1'b0;
    wait1(6);
    rdChk(`OFF_CSR, 8'h42);
    wrReg(`OFF_CSR, 8'h22);
    rdChk(`OFF_CSR, 8'h62);
    check({12'h000, irqMatchCap}, 13'h0001);
    rdChk(`OFF_CAP_L, 8'hf0);
    rdChk(`OFF_CAP_H, 8'h0f);
    rdChk(`OFF_CSR, 8'h22);
    // The counter wraps onto a zero reload and meets the zero duty of channel 1
    wrReg(`OFF_RLD_H, 8'h00);
    wrReg(`OFF_RLD_L, 8'h00);
    wrReg(`OFF_CSR, 8'h10);
    wait1(20);
    rdChk(`OFF_CH_CSR0 + 8'h01, 8'h00);
    rdChk(`OFF_CSR, 8'h14);
    wrReg(`OFF_RLD_L, 8'h33);
    endTest("flags");
    wrReg(`OFF_BRK, 8'h1a);
    faultReq <= 1'b1;
    wait1(8);
    check({9'h000, pwmPin}, 13'h000a);
    rdChk(`OFF_BRK, 8'h3a);
    rdChk(`OFF_RLD_L, 8'h00);
    rdChk(`OFF_OE, 8'h00);
    rdChk(`OFF_DUTY0_H + 8'h01, 8'h00);
    rdChk(`OFF_CNT_L, 8'h00);
    faultReq <= 1'b0;
    wait1(6);
    wrReg(`OFF_BRK, 8'h10);
    wait1(3);
    check({9'h000, pwmPin}, 13'h0005);
    check({9'h000, pwmPinEn}, 13'h0000);
    wrReg(`OFF_BRK, 8'h26);
    wait1(3);
    check({9'h000, pwmPin}, 13'h0006);
    wrReg(`OFF_BRK, 8'h00);
    endTest("break");
    foreach (srcTab[i])
    begin
      wrReg(`OFF_CSR, srcTab[i]);
      rdChk(`OFF_CSR, srcTab[i]);
    end
    endTest("source");
    print_verdict();
  end
endmodule : tb_top
